// file: core/timer_bank_regs.svh
// Purpose: register offsets, field positions and reset values of the
//          four-unit timer bank
// Assumes: byte addresses on a plain register port
// Notes:   definitions only
`ifndef TIMER_BANK_REGS_SVH
`define TIMER_BANK_REGS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define TB_ADDR_W 8
`define TB_OFS_UNIT1_RELOAD 8'h00
`define TB_OFS_UNIT1_COUNT 8'h04
`define TB_OFS_UNIT1_CTRL 8'h08
`define TB_OFS_UNIT1_ACK 8'h0c
`define TB_OFS_UNIT1_STATE 8'h10
`define TB_UNIT_STRIDE 8'h14
`define TB_OFS_UNIT4_ACK 8'h48
`define TB_OFS_UNIT4_STATE 8'h4c
`define TB_OFS_BANK_MASKED 8'ha0
`define TB_OFS_BANK_ACK 8'ha4
`define TB_OFS_BANK_RAW 8'ha8
`define TB_OFS_REVISION 8'hac

// ****************************************************************
// control fields and reset values
// ****************************************************************
`define TB_CTRL_ENABLE 0
`define TB_CTRL_MODE 1
`define TB_CTRL_MASK 2
`define TB_CTRL_RESET 3'h0
`define TB_RELOAD_RESET 24'h00_0000
`define TB_COUNT_MAX 24'hff_ffff
`define TB_REVISION_DEFAULT 32'h0000_0001

`endif

// file: core/timer_bank_pkg.sv
// Purpose: shared types of the timer bank
// Assumes: nothing
// Notes:   numbers live in timer_bank_regs.svh
package timer_bank_pkg;
    typedef logic [23:0] count_t;
    typedef logic [2:0] ctrl_t;
    typedef logic [31:0] word_t;
endpackage : timer_bank_pkg

// file: core/timer_unit_if.sv
// Purpose: bundle between bank decoder and one timer unit
// Assumes: one clock
// Notes:   decoder drives controls, unit returns state
`timescale 1ns/10ps
interface timer_unit_if;
    import timer_bank_pkg::*;
    ctrl_t control;
    count_t reloadValue;
    logic reloadWrite;
    logic irqClear;
    count_t presentCount;
    logic rawIrq;
    modport bank (output control, output reloadValue, output reloadWrite,
        output irqClear, input presentCount, input rawIrq);
    modport unit (input control, input reloadValue, input reloadWrite,
        input irqClear, output presentCount, output rawIrq);
endinterface : timer_unit_if

// file: core/timer_unit.sv
// Purpose: one down-counting timer with a sticky interrupt
// Assumes: control and reload value held by the bank
// Notes:   set of the interrupt wins over a clear in the same cycle
`timescale 1ns/10ps
`include "timer_bank_regs.svh"
module timer_unit
    import timer_bank_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic sys_rst, // sync reset, high
    timer_unit_if.unit port // bank side
);
    count_t count;
    count_t next_count;
    logic irq;
    logic next_irq;
    logic hitZero;

    // ************************************************************
    // counting and interrupt
    // ************************************************************
    // count down, reload or wrap at zero
    always_comb begin
        next_count = count;
        hitZero = 1'b0;
        if (!port.control[`TB_CTRL_ENABLE]) begin
            next_count = port.reloadValue; // disabled: preload
        end else if (count == 24'h00_0000) begin
            hitZero = 1'b1;
            next_count = port.control[`TB_CTRL_MODE] ? port.reloadValue
                : `TB_COUNT_MAX;
        end else begin
            next_count = count - 24'h00_0001;
        end
        // a set beats a clear, so no zero crossing is lost
        next_irq = hitZero | (irq & ~port.irqClear);
    end

    // registers only
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count <= `TB_RELOAD_RESET;
            irq <= 1'b0;
        end else begin
            count <= next_count;
            irq <= next_irq;
        end
    end

    assign port.presentCount = count;
    assign port.rawIrq = irq;
endmodule : timer_unit

// file: core/timer_bank.sv
// Purpose: four-unit down-counting timer bank with interrupt control
// Assumes: plain register port, read data valid one cycle after strobe
// Notes:   unmapped addresses read zero and ignore writes
`timescale 1ns/10ps
`include "timer_bank_regs.svh"
module timer_bank
    import timer_bank_pkg::*;
#(
    parameter int UNITS = 4,
    parameter word_t REVISION = `TB_REVISION_DEFAULT // arbitrary value
) (
    input wire logic clk, // 25 MHz system clock
    input wire logic sys_rst, // sync reset, high
    input wire logic [`TB_ADDR_W-1:0] regAddr, // byte address
    input wire logic [31:0] regWdata, // write data
    input wire logic regWrite, // write strobe
    input wire logic regRead, // read strobe
    output logic [31:0] regRdata, // read data, cycle after strobe
    output logic [UNITS-1:0] timerIrq // masked interrupts, high
);
    timer_unit_if unitPort[UNITS] ();
    ctrl_t control [UNITS];
    ctrl_t next_control [UNITS];
    count_t reloadValue [UNITS];
    count_t next_reloadValue [UNITS];
    logic [UNITS-1:0] rawIrq;
    logic [UNITS-1:0] maskedIrq;
    logic [UNITS-1:0] irqClear;
    logic [UNITS-1:0] reloadWrite;
    count_t presentCount [UNITS];
    word_t rdata;
    word_t next_rdata;
    logic [UNITS-1:0] ctrlHit;
    logic [UNITS-1:0] reloadHit;

    // offset of a register inside unit n's group
    function automatic logic [`TB_ADDR_W-1:0] unitAddr(
        input int n, input logic [`TB_ADDR_W-1:0] base);
        logic [`TB_ADDR_W-1:0] step;
        step = `TB_UNIT_STRIDE * n[`TB_ADDR_W-1:0];
        unitAddr = base + step;
    endfunction : unitAddr

    // ************************************************************
    // timer units
    // ************************************************************
    // one unit per timer, each with its own bundle
    for (genvar n = 0; n < UNITS; n++) begin : g_unit
        assign unitPort[n].control = control[n];
        assign unitPort[n].reloadValue = reloadValue[n];
        assign unitPort[n].reloadWrite = reloadWrite[n];
        assign unitPort[n].irqClear = irqClear[n];
        assign presentCount[n] = unitPort[n].presentCount;
        assign rawIrq[n] = unitPort[n].rawIrq;
        assign maskedIrq[n] = rawIrq[n]
            & ~control[n][`TB_CTRL_MASK];
        assign ctrlHit[n] = regAddr == unitAddr(n, `TB_OFS_UNIT1_CTRL);
        assign reloadHit[n] = regAddr == unitAddr(n, `TB_OFS_UNIT1_RELOAD);
        assign reloadWrite[n] = regWrite & reloadHit[n];
        // per-unit ack or bank ack, each only on a read
        assign irqClear[n] = regRead
            & ((regAddr == unitAddr(n, `TB_OFS_UNIT1_ACK))
            | (regAddr == `TB_OFS_BANK_ACK));
        timer_unit u_unit (
            .clk(clk),
            .sys_rst(sys_rst),
            .port(unitPort[n])
        );
    end

    // output follows the masked state, no extra delay
    assign timerIrq = maskedIrq;

    // ************************************************************
    // writable registers
    // ************************************************************
    // control and reload values, written only at their own offsets
    always_comb begin
        for (int n = 0; n < UNITS; n++) begin
            next_control[n] = control[n];
            next_reloadValue[n] = reloadValue[n];
            if (regWrite && ctrlHit[n]) begin
                next_control[n] = regWdata[2:0];
            end
            if (reloadWrite[n]) begin
                next_reloadValue[n] = regWdata[23:0];
            end
        end
    end

    // registers only
    always_ff @(posedge clk) begin
        for (int n = 0; n < UNITS; n++) begin
            if (sys_rst) begin
                control[n] <= `TB_CTRL_RESET;
                reloadValue[n] <= `TB_RELOAD_RESET;
            end else begin
                control[n] <= next_control[n];
                reloadValue[n] <= next_reloadValue[n];
            end
        end
    end

    // ************************************************************
    // read path
    // ************************************************************
    // data registered so it stands in the cycle after the strobe only;
    // acknowledge offsets fall through to zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (regRead) begin
            for (int n = 0; n < UNITS; n++) begin
                if (reloadHit[n]) begin
                    next_rdata = {8'h00, reloadValue[n]};
                end
                if (regAddr == unitAddr(n, `TB_OFS_UNIT1_COUNT)) begin
                    next_rdata = {8'h00, presentCount[n]};
                end
                if (ctrlHit[n]) begin
                    next_rdata = {29'h0, control[n]};
                end
                if (regAddr == unitAddr(n, `TB_OFS_UNIT1_STATE)) begin
                    next_rdata = {31'h0, rawIrq[n]};
                end
            end
            unique case (regAddr)
                `TB_OFS_BANK_MASKED: begin
                    next_rdata = {28'h0, maskedIrq};
                end
                `TB_OFS_BANK_RAW: begin
                    next_rdata = {28'h0, rawIrq};
                end
                `TB_OFS_REVISION: begin
                    next_rdata = REVISION;
                end
                default: begin
                end
            endcase
        end
    end

    // registers only
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata <= 32'h0000_0000;
        end else begin
            rdata <= next_rdata;
        end
    end

    assign regRdata = rdata;
endmodule : timer_bank

// file: testbench/timer_bank_checker.sv
// Purpose: assertions on the timer bank register port
// Assumes: four units, unit four is timerIrq msb
// Notes: bound to every timer_bank instance
`timescale 1ns/10ps
module timer_bank_checker
    import timer_bank_pkg::*;
#(
    parameter int UNITS = 4,
    parameter word_t REVISION = 32'h0000_0001 // arbitrary value
) (
    input wire logic clk, // system clock
    input wire logic sys_rst, // sync reset, high
    input wire logic [7:0] regAddr, // byte address
    input wire logic [31:0] regWdata, // write data
    input wire logic regWrite, // write strobe
    input wire logic regRead, // read strobe
    input wire logic [31:0] regRdata, // read data
    input wire logic [UNITS-1:0] timerIrq // masked interrupts
);
    // ********************
    // register port checks
    // ********************
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // a read strobe at one offset, answer lands a cycle later
    sequence rdAt(logic [7:0] a);
        regRead && regAddr == a;
    endsequence
    idle_rdata_zero_a: assert property (
        !regRead |=> regRdata == 32'h0000_0000)
        else $error("read data not zero outside a read");
    unit_ack_zero_a: assert property (
        rdAt(8'h48) |=> regRdata == 32'h0000_0000)
        else $error("unit four ack read not zero");
    bank_ack_zero_a: assert property (
        rdAt(8'ha4) |=> regRdata == 32'h0000_0000)
        else $error("bank ack read not zero");
    masked_matches_a: assert property (rdAt(8'ha0) |=>
        regRdata == 32'($past(timerIrq))) else $error("masked state off");
    raw_covers_a: assert property (
        rdAt(8'ha8) |=> regRdata[31:UNITS] == 0
        && (regRdata[UNITS-1:0] & $past(timerIrq)) == $past(timerIrq))
        else $error("raw state misses an interrupt");
    unit_state_a: assert property (
        rdAt(8'h4c) |=> regRdata[31:1] == 0
        && regRdata[0] >= $past(timerIrq[UNITS-1]))
        else $error("unit four state wrong");
    revision_word_a: assert property (
        rdAt(8'hac) |=> regRdata == REVISION)
        else $error("revision word wrong");
    // readback words keep their reserved upper byte at zero
    reload_upper_a: assert property (
        rdAt(8'h3c) |=> regRdata[31:24] == 8'h00)
        else $error("reload upper bits set");
    count_upper_a: assert property (
        rdAt(8'h40) |=> regRdata[31:24] == 8'h00)
        else $error("count upper bits set");
    // a mask written to unit four silences its output from the next cycle
    mask_silences_a: assert property (
        regWrite && regAddr == 8'h44 && regWdata[2] |=> !timerIrq[UNITS-1])
        else $error("masked unit four still interrupts");
    // reset itself must clear, so the default disable is lifted here
    reset_clears_a: assert property (disable iff (1'b0)
        sys_rst |=> timerIrq == '0 && regRdata == 32'h0000_0000)
        else $error("reset left state");
endmodule : timer_bank_checker

bind timer_bank timer_bank_checker #(.UNITS(UNITS), .REVISION(REVISION))
    u_timer_bank_checker (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .timerIrq(timerIrq));

// file: testbench/timer_bank_tb.sv
// Purpose: register level tests of the timer bank
// Assumes: reads answer one cycle after the strobe
// Notes: waits are bounded, a hang ends the run
`timescale 1ns/10ps
module timer_bank_tb;
    localparam logic [31:0] REV = 32'h0000_0a5c; // arbitrary value
    logic clk;
    logic sys_rst;
    logic regWrite;
    logic regRead;
    logic [7:0] regAddr;
    logic [31:0] regWdata;
    logic [31:0] regRdata;
    logic [3:0] timerIrq;
    int failures = 0;
    int nTests = 0;
    timer_bank #(.UNITS(4), .REVISION(REV)) u_timer_bank (.clk(clk),
        .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .timerIrq(timerIrq));
    // ********************
    // clock and bus tasks
    // ********************
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : wr
    // data stand only in the cycle after the strobe, so sample mid-cycle
    task automatic rd(string name, logic [7:0] a, logic [31:0] exp,
            logic [31:0] msk = 32'hffff_ffff);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        @(negedge clk);
        chk(name, regRdata & msk, exp);
    endtask : rd
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", nTests, failures);
        if (failures == 0 && nTests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic wait_irq(logic [3:0] want);
        for (int i = 0; i < 64 && timerIrq !== want; i++) @(negedge clk);
        chk("timerIrq", 32'(timerIrq), 32'(want));
        if (timerIrq !== want) tally_and_finish();
    endtask : wait_irq
    // ********************
    // test sequence
    // ********************
    initial begin
        sys_rst = 1'b1;
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 8'h00;
        regWdata = 32'h0;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        rd("revision", 8'hac, REV);
        wr(8'hac, 32'hffff_ffff);
        rd("revision kept", 8'hac, REV);
        rd("ctrl reset", 8'h44, 32'h0);
        rd("unmapped", 8'hfc, 32'h0);
        wr(8'h3c, 32'hffff_ffff);
        rd("reload upper", 8'h3c, 32'h00ff_ffff);
        wr(8'h28, 32'h1234_5678);
        rd("reload three", 8'h28, 32'h0034_5678);
        $display("test reset done");
        // user count on unit four, then mask and acknowledge it
        wr(8'h3c, 32'h0000_0003);
        wr(8'h44, 32'h0000_0003);
        rd("ctrl back", 8'h44, 32'h3);
        wait_irq(4'h8);
        // zero hit one edge ago: reloaded to 3, then one step down
        rd("reloaded", 8'h40, 32'h2);
        wr(8'h44, 32'h0000_0002);
        rd("count preload", 8'h40, 32'h3);
        rd("unit state", 8'h4c, 32'h1);
        rd("masked on", 8'ha0, 32'h8);
        wr(8'h44, 32'h0000_0006);
        rd("masked off", 8'ha0, 32'h0);
        chk("irq masked", 32'(timerIrq), 32'h0);
        rd("raw on", 8'ha8, 32'h8);
        rd("unit ack", 8'h48, 32'h0);
        rd("unit cleared", 8'h4c, 32'h0);
        $display("test user mode done");
        // free run on unit four beside unit one, then one bank clear
        wr(8'h00, 32'h0000_0001);
        wr(8'h08, 32'h0000_0003);
        wr(8'h3c, 32'h0000_0002);
        wr(8'h44, 32'h0000_0001);
        wait_irq(4'h9);
        rd("wrapped", 8'h40, 32'h00ff_0000, 32'hffff_0000);
        wr(8'h08, 32'h0);
        wr(8'h44, 32'h0);
        rd("both set", 8'ha0, 32'h9);
        rd("unit one state", 8'h10, 32'h1);
        rd("bank ack", 8'ha4, 32'h0);
        chk("irq acked", 32'(timerIrq), 32'h0);
        rd("raw cleared", 8'ha8, 32'h0);
        $display("test bank ack done");
        // a reset in mid-run clears control and reload words
        wr(8'h44, 32'h0000_0007);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rd("ctrl after reset", 8'h44, 32'h0);
        rd("reload after reset", 8'h3c, 32'h0);
        $display("test mid reset done");
        tally_and_finish();
    end
endmodule : timer_bank_tb
